// ---- rtl/static_mem_bank_timing.sv ----
/*
 static-memory controller: three chip-select banks on an 8/16-bit external bus, per-bank
 width, wait and byte-lane mode, programmable setup/access/hold timing, register port.
 assumes requests from on-chip logic on i_clk_sys; the wait pin and straps are asynchronous.
*/
//
// Contract
// - bit 9 gives chip select 2 to this controller (0) or the NAND controller (1)
// - byte-lane mode bits 8,5,2: 0 write byte enables, 1 upper/lower byte enables
// - wait-enable bits 7,4,1: honour the external wait input for that bank
// - width bits 6,3 choose 8-bit or 16-bit bus for banks 2,1
// - bank 0 width bit is read-only, captured from the strap pin
// - address setup before chip select: 0,2,4,8 clocks; code 0 gives 1 clock here
// - chip select setup before strobe: 0,2,4,8 clocks; code 0 gives 1 clock here
// - strobe length 2,3,4,10,12,14,16,20 clocks; field resets to 111
// - chip select hold after strobe: 0,2,4,8 clocks; code 0 gives 1 clock here
// - address hold after chip select: 0,2,4,8 clocks; code 0 gives 1 clock here
// - three timing registers, each reset to 0x0700
// - wait low stretches strobe; sampled from the last count onward, release one clock later
// - on NAND boot chip select 0 belongs to the NAND controller, no bank 0 cycles
// - each bank decodes 64MB at a fixed base; byte, half and word accesses
`timescale 1ns/10ps
`default_nettype none
`include "static_mem_map.svh"
module static_mem_bank_timing #(
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_srst,
	input  wire logic [31:0]               i_reg_addr,
	input  wire logic [15:0]               i_reg_wdata,
	input  wire logic                      i_reg_write,
	input  wire logic                      i_reg_read,
	output logic      [15:0]               o_reg_rdata,
	input  wire logic                      i_req_valid,
	output logic                           o_req_ready,
	input  wire static_mem_pkg::mem_req_s  i_req,
	output logic                           o_rsp_valid,
	output static_mem_pkg::mem_rsp_s       o_rsp,
	input  wire logic                      i_width_strap,
	input  wire logic                      i_ext_wait_n,
	output logic      [2:0]                o_bank_select_n,
	output logic                           o_output_strobe_n,
	output logic                           o_write_strobe_n,
	output logic      [1:0]                o_byte_lane_strobe_n,
	output logic      [25:0]               o_addr,
	output logic      [15:0]               o_data_out,
	output logic                           o_data_oe,
	input  wire logic [15:0]               i_data_in
);
	typedef enum {st_idle, st_addr_setup, st_cs_setup, st_access, st_cs_hold, st_addr_hold} state_e;

	function automatic logic [4:0] setup_clocks(input logic [1:0] code);
		case (code)
			2'h0:    setup_clocks = 5'h00;
			2'h1:    setup_clocks = 5'h02;
			2'h2:    setup_clocks = 5'h04;
			default: setup_clocks = 5'h08;
		endcase
	endfunction : setup_clocks

	function automatic logic [4:0] access_clocks(input logic [2:0] code);
		case (code)
			3'h0:    access_clocks = 5'h02;
			3'h1:    access_clocks = 5'h03;
			3'h2:    access_clocks = 5'h04;
			3'h3:    access_clocks = 5'h0A;
			3'h4:    access_clocks = 5'h0C;
			3'h5:    access_clocks = 5'h0E;
			3'h6:    access_clocks = 5'h10;
			default: access_clocks = 5'h14;
		endcase
	endfunction : access_clocks

	// synchronisers for the pins from outside the clock domain
	logic [1:0] wait_sync, strap_sync;
	always_ff @(posedge i_clk_sys) begin
		wait_sync  <= {wait_sync[0], i_ext_wait_n};
		strap_sync <= {strap_sync[0], i_width_strap};
	end

	// ---- registers ----
	logic [15:0] width_wait, next_width_wait;
	logic [15:0] timing [3];
	logic [15:0] next_timing [3];
	logic        nand_boot, next_nand_boot;
	logic        strap_taken, next_strap_taken;
	logic [15:0] next_reg_rdata;
	logic        busy;

	always_comb begin
		next_width_wait  = width_wait;
		next_nand_boot   = nand_boot;
		next_strap_taken = 1'b1;
		for (int b = 0; b < 3; b++) begin
			next_timing[b] = timing[b];
		end
		if (!strap_taken) begin
			next_width_wait[`SMC_BIT_BANK0_WIDTH] = strap_sync[1];
		end
		if (i_reg_write) begin
			case (i_reg_addr)
				// keep the strap bit taken in this same cycle, a write must not undo the capture
				`SMC_OFS_WIDTH_WAIT: next_width_wait = (i_reg_wdata & `SMC_WW_MASK)
					| (next_width_wait & ~`SMC_WW_MASK);
				`SMC_OFS_BANK0_TIMING: next_timing[0] = i_reg_wdata & `SMC_TIMING_MASK;
				`SMC_OFS_BANK1_TIMING: next_timing[1] = i_reg_wdata & `SMC_TIMING_MASK;
				`SMC_OFS_BANK2_TIMING: next_timing[2] = i_reg_wdata & `SMC_TIMING_MASK;
				`SMC_OFS_BOOT_CTRL:    next_nand_boot = i_reg_wdata[0];
				default: ;
			endcase
		end
		next_reg_rdata = 16'h0000;
		if (i_reg_read) begin
			case (i_reg_addr)
				`SMC_OFS_WIDTH_WAIT:   next_reg_rdata = width_wait;
				`SMC_OFS_BANK0_TIMING: next_reg_rdata = timing[0];
				`SMC_OFS_BANK1_TIMING: next_reg_rdata = timing[1];
				`SMC_OFS_BANK2_TIMING: next_reg_rdata = timing[2];
				`SMC_OFS_BOOT_CTRL:    next_reg_rdata = {15'h0000, nand_boot};
				`SMC_OFS_STATUS:       next_reg_rdata = {15'h0000, busy};
				default:               next_reg_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			width_wait  <= 16'h0000;
			nand_boot   <= 1'b0;
			strap_taken <= 1'b0;
			o_reg_rdata <= 16'h0000;
			for (int b = 0; b < 3; b++) begin
				timing[b] <= `SMC_TIMING_RESET;
			end
		end else begin
			width_wait  <= next_width_wait;
			nand_boot   <= next_nand_boot;
			strap_taken <= next_strap_taken;
			o_reg_rdata <= next_reg_rdata;
			for (int b = 0; b < 3; b++) begin
				timing[b] <= next_timing[b];
			end
		end
	end

	// ---- request buffer ----
	localparam int REQ_W = $bits(static_mem_pkg::mem_req_s);
	logic                     fifo_valid, fifo_pop;
	logic [REQ_W-1:0]         fifo_data;
	static_mem_pkg::mem_req_s cur;
	assign cur = static_mem_pkg::mem_req_s'(fifo_data);

	smc_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk_sys  (i_clk_sys),
		.i_srst     (i_srst),
		.i_in_valid (i_req_valid),
		.o_in_ready (o_req_ready),
		.i_in_data  (REQ_W'(i_req)),
		.o_out_valid(fifo_valid),
		.i_out_ready(fifo_pop),
		.o_out_data (fifo_data)
	);

	// ---- access sequencer ----
	state_e      state, next_state;
	logic [4:0]  cnt, next_cnt;
	logic [1:0]  beat, next_beat, beats;
	logic [1:0]  bank;
	logic [15:0] tm;
	logic        wide, bank_ok;
	logic [31:0] rdata, next_rdata;
	logic        next_rsp_valid;
	logic [25:0] beat_addr;
	logic [1:0]  lanes;
	logic        wait_hold;

	always_comb begin
		bank    = cur.addr[`SMC_BANK_SEL_HI:`SMC_BANK_SEL_LO];
		tm      = timing[bank];
		wide    = (bank == 2'h0) ? width_wait[0] : (bank == 2'h1) ? width_wait[3] : width_wait[6];
		// a bank owned by the NAND controller when its request leaves idle is never driven from here
		bank_ok = (bank == 2'h0) ? !nand_boot : (bank == 2'h1) ? 1'b1 :
			(bank == 2'h2) ? !width_wait[`SMC_BIT_CS2_OWNER] : 1'b0;
		case (cur.size)
			static_mem_pkg::size_byte: beats = 2'h0;
			static_mem_pkg::size_half: beats = wide ? 2'h0 : 2'h1;
			default:                   beats = wide ? 2'h1 : 2'h3;
		endcase
		wait_hold = width_wait[3 * 32'(bank) + 1] && !wait_sync[1];
		next_state     = state;
		next_cnt       = cnt;
		next_beat      = beat;
		next_rdata     = rdata;
		next_rsp_valid = 1'b0;
		fifo_pop       = 1'b0;
		case (state)
			st_idle: if (fifo_valid) begin
				if (!bank_ok) begin
					fifo_pop       = 1'b1;
					next_rsp_valid = !cur.write;
					next_rdata     = 32'h0000_0000;
				end else begin
					next_state = st_addr_setup;
					next_cnt   = setup_clocks(tm[`SMC_FLD_TACS_HI:`SMC_FLD_TACS_LO]);
				end
			end
			st_addr_setup: if (cnt > 5'h01) next_cnt = cnt - 5'h01; else begin
				next_state = st_cs_setup;
				next_cnt   = setup_clocks(tm[`SMC_FLD_TCOS_HI:`SMC_FLD_TCOS_LO]);
			end
			st_cs_setup: if (cnt > 5'h01) next_cnt = cnt - 5'h01; else begin
				next_state = st_access;
				next_cnt   = access_clocks(tm[`SMC_FLD_TACC_HI:`SMC_FLD_TACC_LO]);
			end
			st_access: begin
				// wait is looked at from the last count onward; strobe ends the clock after it reads high
				if (cnt > 5'h01) next_cnt = cnt - 5'h01;
				else if (!wait_hold) begin
					next_state = st_cs_hold;
					next_cnt   = setup_clocks(tm[`SMC_FLD_TCOH_HI:`SMC_FLD_TCOH_LO]);
					if (wide) next_rdata[16 * 32'(beat[0]) +: 16] = i_data_in;
					else next_rdata[8 * 32'(beat) +: 8] = i_data_in[7:0];
				end
			end
			st_cs_hold: if (cnt > 5'h01) next_cnt = cnt - 5'h01; else begin
				next_state = st_addr_hold;
				next_cnt   = setup_clocks(tm[`SMC_FLD_TCAH_HI:`SMC_FLD_TCAH_LO]);
			end
			st_addr_hold: if (cnt > 5'h01) next_cnt = cnt - 5'h01; else if (beat != beats) begin
				next_beat  = beat + 2'h1;
				next_state = st_addr_setup;
				next_cnt   = setup_clocks(tm[`SMC_FLD_TACS_HI:`SMC_FLD_TACS_LO]);
			end else begin
				next_beat      = 2'h0;
				next_state     = st_idle;
				fifo_pop       = 1'b1;
				next_rsp_valid = !cur.write;
			end
			default: next_state = st_idle;
		endcase
		// address follows the coming beat so the whole setup time sees the new address
		beat_addr = wide ? {cur.addr[25:2], cur.addr[1] | next_beat[0], cur.addr[0]}
			: cur.addr[25:0] | {24'h000000, next_beat};
		busy = (state != st_idle);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			state       <= st_idle;
			cnt         <= 5'h00;
			beat        <= 2'h0;
			rdata       <= 32'h0000_0000;
			o_rsp_valid <= 1'b0;
		end else begin
			state       <= next_state;
			cnt         <= next_cnt;
			beat        <= next_beat;
			rdata       <= next_rdata;
			o_rsp_valid <= next_rsp_valid;
		end
	end
	assign o_rsp.rdata = rdata;

	// ---- pin drive, registered ----
	logic [2:0]  next_cs_n;
	logic        next_oe_n, next_we_n, next_doe, strobe, lane_mode;
	logic [1:0]  next_lane_n;
	logic [15:0] next_dout;
	always_comb begin
		lanes     = wide ? (cur.size == static_mem_pkg::size_byte ? {cur.addr[0], !cur.addr[0]} : 2'h3) : 2'h1;
		lane_mode = width_wait[3 * 32'(bank) + 2];
		strobe    = (next_state == st_access);
		next_cs_n = 3'h7;
		if (next_state == st_cs_setup || next_state == st_access || next_state == st_cs_hold) begin
			next_cs_n[bank] = 1'b0;
		end
		next_oe_n   = !(strobe && !cur.write);
		next_we_n   = !(strobe && cur.write);
		// write byte enables pulse with the write strobe, upper/lower enables span the strobe
		next_lane_n = (strobe && (lane_mode || cur.write)) ? ~lanes : 2'h3;
		next_doe    = cur.write && (next_state != st_idle);
		next_dout   = wide ? cur.wdata[16 * 32'(beat[0]) +: 16] : {8'h00, cur.wdata[8 * 32'(beat) +: 8]};
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_bank_select_n      <= 3'h7;
			o_output_strobe_n    <= 1'b1;
			o_write_strobe_n     <= 1'b1;
			o_byte_lane_strobe_n <= 2'h3;
			o_addr               <= 26'h0000000;
			o_data_out           <= 16'h0000;
			o_data_oe            <= 1'b0;
		end else begin
			o_bank_select_n      <= next_cs_n;
			o_output_strobe_n    <= next_oe_n;
			o_write_strobe_n     <= next_we_n;
			o_byte_lane_strobe_n <= next_lane_n;
			o_addr               <= (next_state == st_idle) ? o_addr : beat_addr;
			o_data_out           <= next_dout;
			o_data_oe            <= next_doe;
		end
	end
endmodule : static_mem_bank_timing
`default_nettype wire

// ---- rtl/static_mem_map.svh ----
/*
 register map, field positions, reset values and masks of the static-memory controller.
 assumes inclusion by its bare name from the design file, the checker and the bench.
*/
`ifndef STATIC_MEM_MAP_SVH
`define STATIC_MEM_MAP_SVH
`define SMC_OFS_WIDTH_WAIT   32'h40C2_0000
`define SMC_OFS_BANK0_TIMING 32'h40C2_0004
`define SMC_OFS_BANK1_TIMING 32'h40C2_0008
`define SMC_OFS_BANK2_TIMING 32'h40C2_000C
`define SMC_OFS_BOOT_CTRL    32'h40C2_0010
`define SMC_OFS_STATUS       32'h40C2_0014
`define SMC_TIMING_RESET     16'h0700
`define SMC_TIMING_MASK      16'hF7F0
`define SMC_WW_MASK          16'h03FE
`define SMC_BIT_CS2_OWNER    9
`define SMC_BIT_BANK0_WIDTH  0
`define SMC_FLD_TACS_HI      15
`define SMC_FLD_TACS_LO      14
`define SMC_FLD_TCOS_HI      13
`define SMC_FLD_TCOS_LO      12
`define SMC_FLD_TACC_HI      10
`define SMC_FLD_TACC_LO      8
`define SMC_FLD_TCOH_HI      7
`define SMC_FLD_TCOH_LO      6
`define SMC_FLD_TCAH_HI      5
`define SMC_FLD_TCAH_LO      4
`define SMC_BANK_ADDR_BITS   26
`define SMC_BANK_SEL_HI      27
`define SMC_BANK_SEL_LO      26
`endif

// ---- rtl/static_mem_pkg.sv ----
/*
 types shared by the static-memory controller: request and answer carriers, access sizes.
 assumes the map header sits beside it.
*/
package static_mem_pkg;
	typedef enum logic [1:0] {size_byte, size_half, size_word} access_size_e;
	typedef struct packed {
		logic         write;
		logic [27:0]  addr;
		access_size_e size;
		logic [31:0]  wdata;
	} mem_req_s;
	typedef struct packed {
		logic [31:0] rdata;
	} mem_rsp_s;
endpackage : static_mem_pkg

// ---- rtl/smc_fifo.sv ----
/*
 request fifo of the static-memory controller, flip-flop storage.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module smc_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_srst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0]      count, next_count;
	logic             push, pop;
	always_comb begin
		o_in_ready  = (count != (AW+1)'(DEPTH));
		o_out_valid = (count != '0);
		o_out_data  = mem[rd_ptr];
		push        = i_in_valid && o_in_ready;
		pop         = o_out_valid && i_out_ready;
		next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
		next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end
endmodule : smc_fifo
`default_nettype wire

// ---- verif/static_mem_bank_timing_checker.sv ----
/*
 port-level assertions of the static-memory controller.
 assumes a bind onto every instance of the top module, one clock, sync reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "static_mem_map.svh"
module static_mem_bank_timing_checker (
	input wire logic        i_clk_sys,
	input wire logic        i_srst,
	input wire logic [31:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic        i_reg_write,
	input wire logic        i_reg_read,
	input wire logic [15:0] o_reg_rdata,
	input wire logic        i_width_strap,
	input wire logic [2:0]  o_bank_select_n,
	input wire logic        o_output_strobe_n,
	input wire logic        o_write_strobe_n,
	input wire logic        o_data_oe
);
	logic owner;
	logic next_owner;
	always_comb begin
		next_owner = owner;
		if (i_reg_write && i_reg_addr == `SMC_OFS_WIDTH_WAIT) begin
			next_owner = i_reg_wdata[`SMC_BIT_CS2_OWNER];
		end
	end
	always_ff @(posedge i_clk_sys) begin
		owner <= i_srst ? 1'b0 : next_owner;
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	a_rdata_idle_zero: assert property (!$past(i_reg_read) |-> o_reg_rdata == 16'h0000)
		else $error("read data not zero outside read answer");
	a_unmapped_reads_zero: assert property ($past(i_reg_read) && $past(i_reg_addr) > `SMC_OFS_STATUS
		|-> o_reg_rdata == 16'h0000) else $error("unmapped read not zero");
	a_strap_width_bit: assert property ($past(i_reg_read) && $past(i_reg_addr) == `SMC_OFS_WIDTH_WAIT
		|-> o_reg_rdata[0] == i_width_strap) else $error("bank0 width bit differs from strap");
	a_strobes_exclusive: assert property (!(!o_output_strobe_n && !o_write_strobe_n))
		else $error("both strobes low");
	a_select_one_hot: assert property ($onehot0(~o_bank_select_n))
		else $error("more than one bank selected");
	a_strobe_in_select: assert property (!(o_output_strobe_n && o_write_strobe_n) |-> !(&o_bank_select_n))
		else $error("strobe without chip select");
	a_strobe_min_len: assert property ($fell(o_output_strobe_n) |-> (!o_output_strobe_n)[*2])
		else $error("output strobe shorter than two clocks");
	a_cs2_owner_off: assert property (owner |-> o_bank_select_n[2])
		else $error("bank2 selected while owned elsewhere");
	a_write_drives_data: assert property (!o_write_strobe_n |-> o_data_oe)
		else $error("write strobe without data drive");
endmodule : static_mem_bank_timing_checker
bind static_mem_bank_timing static_mem_bank_timing_checker static_mem_bank_timing_checker_inst (
	.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
	.i_width_strap(i_width_strap), .o_bank_select_n(o_bank_select_n),
	.o_output_strobe_n(o_output_strobe_n), .o_write_strobe_n(o_write_strobe_n), .o_data_oe(o_data_oe));
`default_nettype wire

// ---- verif/static_mem_model.sv ----
/*
 behavioural 8-bit asynchronous memory on the far side of the controller.
 assumes byte addresses on the low address bits and lane 0 for data.
*/
`timescale 1ns/10ps
`default_nettype none
module static_mem_model (
	input  wire logic        i_clk_sys,
	input  wire logic [2:0]  i_bank_select_n,
	input  wire logic        i_output_strobe_n,
	input  wire logic        i_write_strobe_n,
	input  wire logic [25:0] i_addr,
	input  wire logic [15:0] i_data,
	input  wire logic [3:0]  i_wait_len,
	output logic             o_ext_wait_n,
	output logic      [15:0] o_data
);
	logic [7:0] mem [0:255];
	logic [3:0] wait_cnt = 4'h0;
	logic       strobe_q = 1'b1;
	wire logic  sel = ~&i_bank_select_n;
	wire logic  strobe = i_output_strobe_n & i_write_strobe_n;
	initial o_data = 16'h0000;
	// wait pulled low from the cycle after a strobe falls, for the asked length
	assign o_ext_wait_n = (wait_cnt == 4'h0);
	always @(posedge i_clk_sys) begin
		strobe_q <= strobe;
		if (strobe_q && !strobe) wait_cnt <= i_wait_len;
		else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
		if (sel && !i_write_strobe_n) mem[i_addr[7:0]] <= i_data[7:0];
		// released bus toggles so a stale value is never mistaken for data
		if (sel && !i_output_strobe_n) o_data <= {8'h00, mem[i_addr[7:0]]};
		else o_data <= ~o_data;
	end
endmodule : static_mem_model
`default_nettype wire

// ---- verif/static_mem_bank_timing_bench.sv ----
/*
 self-checking bench of the static-memory controller with a far-side memory model.
 assumes the checker is bound by its own file; strap drawn at random and held from time zero.
*/
`timescale 1ns/10ps
`default_nettype none
`include "static_mem_map.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module static_mem_bank_timing_bench;
	logic                      clk = 1'b0, srst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, strap = 1'b0;
	logic [31:0]               reg_addr = 32'h0;
	logic [15:0]               reg_wdata = 16'h0, reg_rdata, dout, din;
	logic                      req_valid = 1'b0, req_ready, rsp_valid, wait_n, oe_n, we_n, doe;
	static_mem_pkg::mem_req_s  req = '0;
	static_mem_pkg::mem_rsp_s  rsp;
	logic [2:0]                sel_n, sel_seen;
	logic [1:0]                lanes_n;
	logic [25:0]               addr;
	logic [3:0]                wait_len = 4'h0;
	logic                      we_q = 1'b1, lane_rd, saw_full;
	int errors = 0, num_checks = 0, oe_run = 0, oe_len = 0, cs_run = 0, cs_oe = 0, cs_hd = 0, we_falls = 0;
	int rsp_cnt = 0;
	static_mem_bank_timing static_mem_bank_timing_inst (.i_clk_sys(clk), .i_srst(srst), .i_reg_addr(reg_addr),
		.i_reg_wdata(reg_wdata), .i_reg_write(reg_write), .i_reg_read(reg_read), .o_reg_rdata(reg_rdata),
		.i_req_valid(req_valid), .o_req_ready(req_ready), .i_req(req), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
		.i_width_strap(strap), .i_ext_wait_n(wait_n), .o_bank_select_n(sel_n), .o_output_strobe_n(oe_n),
		.o_write_strobe_n(we_n), .o_byte_lane_strobe_n(lanes_n), .o_addr(addr), .o_data_out(dout),
		.o_data_oe(doe), .i_data_in(din));
	static_mem_model static_mem_model_inst (.i_clk_sys(clk), .i_bank_select_n(sel_n), .i_output_strobe_n(oe_n),
		.i_write_strobe_n(we_n), .i_addr(addr), .i_data(dout), .i_wait_len(wait_len), .o_ext_wait_n(wait_n),
		.o_data(din));
	initial forever #50 clk = ~clk;
	// port monitor: strobe lengths, select-to-strobe delay, beat counts
	always @(posedge clk) begin
		if (!oe_n) oe_run++;
		else if (oe_run != 0) begin
			oe_len = oe_run;
			oe_run = 0;
		end
		if (&sel_n) begin
			if (cs_run != 0) cs_hd = cs_run;
			cs_run = 0;
		end
		else if (oe_n && we_n) cs_run++;
		else if (cs_run != 0) begin
			cs_oe = cs_run;
			cs_run = 0;
		end
		if (!we_n && we_q) we_falls++;
		we_q = we_n;
		if (!oe_n && lanes_n != 2'b11) lane_rd = 1'b1;
		if (req_valid && !req_ready) saw_full = 1'b1;
		sel_seen = sel_seen | ~sel_n;
		if (rsp_valid === 1'b1) rsp_cnt++;
	end
	function automatic int tacc_clk(input int c);
		int t[8] = '{2, 3, 4, 10, 12, 14, 16, 20};
		return t[c];
	endfunction : tacc_clk
	function automatic int setup_clk(input logic [1:0] c);
		return (c == 2'b00) ? 1 : (1 << c);
	endfunction : setup_clk
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask : rd
	task automatic push(input logic w, input logic [27:0] a, input static_mem_pkg::access_size_e sz,
		input logic [31:0] d);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{w, a, sz, d};
		@(posedge clk);
		while (req_ready !== 1'b1) @(posedge clk);
		req_valid <= 1'b0;
	endtask : push
	// the sequencer idles one cycle between queued requests, so two idle polls in a row are needed
	task automatic wait_idle();
		logic [15:0] s;
		int          idle;
		idle = 0;
		repeat (4) @(posedge clk);
		for (int k = 0; k < 2000 && idle < 2; k++) begin
			rd(`SMC_OFS_STATUS, s);
			idle = (s[0] === 1'b0) ? idle + 1 : 0;
		end
	endtask : wait_idle
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial begin
		#8000000;
		errors++;
		tally_and_finish();
	end
	initial begin
		logic [15:0] d, t;
		logic [7:0]  v;
		logic [31:0] w;
		int          n;
		void'($urandom(12));
		strap <= 1'($urandom);
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rd(`SMC_OFS_WIDTH_WAIT, d); `CHK(d, {15'h0000, strap})
		for (int b = 0; b < 3; b++) begin
			rd(`SMC_OFS_BANK0_TIMING + 4 * b, d); `CHK(d, `SMC_TIMING_RESET)
		end
		rd(32'h40C2_0018, d); `CHK(d, 16'h0000)
		wr(`SMC_OFS_WIDTH_WAIT, 16'hFFFF);
		rd(`SMC_OFS_WIDTH_WAIT, d); `CHK(d, 16'h03FE | {15'h0000, strap})
		wr(`SMC_OFS_WIDTH_WAIT, 16'h0000);
		for (int b = 0; b < 3; b++) begin
			t = 16'($urandom);
			wr(`SMC_OFS_BANK0_TIMING + 4 * b, t);
			rd(`SMC_OFS_BANK0_TIMING + 4 * b, d); `CHK(d, t & 16'hF7F0)
		end
		// every access code, random setup and hold around it
		for (int c = 0; c < 8; c++) begin
			t = {2'($urandom), 2'($urandom), 1'b0, 3'(c), 2'($urandom), 2'($urandom), 4'h0};
			v = 8'($urandom);
			wr(`SMC_OFS_BANK1_TIMING, t);
			push(1'b1, {2'd1, 18'h0, 8'(c)}, static_mem_pkg::size_byte, {24'h0, v});
			wait_idle();
			push(1'b0, {2'd1, 18'h0, 8'(c)}, static_mem_pkg::size_byte, 32'h0);
			wait_idle();
			`CHK(rsp.rdata[7:0], v)
			`CHK(oe_len, tacc_clk(c))
			`CHK(cs_oe, setup_clk(t[13:12]))
			`CHK(cs_hd, setup_clk(t[7:6]))
		end
		// lane mode 1 without wait, then wait enabled with lane mode 0; four-clock strobe leaves room for the wait sync
		wr(`SMC_OFS_BANK1_TIMING, 16'h0200);
		wait_len <= 4'h6;
		for (int e = 0; e < 2; e++) begin
			wr(`SMC_OFS_WIDTH_WAIT, e ? 16'h0010 : 16'h0020);
			lane_rd = 1'b0;
			push(1'b0, {2'd1, 26'h0}, static_mem_pkg::size_byte, 32'h0);
			wait_idle();
			`CHK(lane_rd, e ? 1'b0 : 1'b1)
			`CHK(oe_len > 6, e == 1)
			`CHK(oe_len < 12, 1'b1)
		end
		wait_len <= 4'h0;
		wr(`SMC_OFS_WIDTH_WAIT, 16'h0000);
		wr(`SMC_OFS_BANK2_TIMING, 16'h0000);
		w = $urandom;
		n = we_falls;
		push(1'b1, {2'd2, 26'h10}, static_mem_pkg::size_word, w);
		wait_idle();
		`CHK(we_falls - n, 4)
		push(1'b0, {2'd2, 26'h10}, static_mem_pkg::size_word, 32'h0);
		wait_idle();
		`CHK(rsp.rdata, w)
		// refused banks: nand boot, bank2 handed over, bank3 unmapped
		wr(`SMC_OFS_WIDTH_WAIT, 16'h0200);
		wr(`SMC_OFS_BOOT_CTRL, 16'h0001);
		sel_seen = 3'b000;
		for (int b = 0; b < 4; b++) begin
			if (b != 1) begin
				push(1'b0, {2'(b), 26'h0}, static_mem_pkg::size_byte, 32'h0);
				wait_idle();
				`CHK(rsp.rdata, 32'h0)
			end
		end
		`CHK(sel_seen, 3'b000)
		wr(`SMC_OFS_BOOT_CTRL, 16'h0000);
		wr(`SMC_OFS_WIDTH_WAIT, 16'h0000);
		// slow accesses so the request buffer fills and refuses
		wr(`SMC_OFS_BANK1_TIMING, 16'h0700);
		saw_full = 1'b0;
		n = rsp_cnt;
		repeat (10) push(1'b0, {2'd1, 26'h0}, static_mem_pkg::size_byte, 32'h0);
		wait_idle();
		`CHK(saw_full, 1'b1)
		`CHK(rsp_cnt - n, 10)
		tally_and_finish();
	end
endmodule : static_mem_bank_timing_bench
`default_nettype wire
